//--- hw/fsrc_pkg.sv
`default_nettype none
package fsrc_pkg;
    // ******************************************************
    // instruction codes
    // ******************************************************
    localparam logic [7:0] OP_ERS_SUSPEND = 8'h75;
    localparam logic [7:0] OP_ERS_RESUME  = 8'h7a;
    localparam logic [7:0] OP_PGM_SUSPEND = 8'h85;
    localparam logic [7:0] OP_PGM_RESUME  = 8'h8a;
    localparam logic [7:0] OP_RD_PARAM    = 8'h5a;
    // ******************************************************
    // parameter dwords (little endian on read-back)
    // ******************************************************
    localparam logic [31:0] DW12_VALUE = 32'h451883ec;
    localparam logic [31:0] DW13_VALUE = 32'h757a858a;
    localparam logic [7:0]  DW12_ADDR  = 8'h2c;
    localparam logic [7:0]  DW13_ADDR  = 8'h30;
    localparam int          SUP_FLAG_BIT = 31;
    localparam int          UNIT_HI = 30;
    localparam int          UNIT_LO = 29;
    localparam int          ECNT_HI = 28;
    localparam int          ECNT_LO = 24;
    localparam int          PCNT_HI = 17;
    localparam int          PCNT_LO = 13;
    // ******************************************************
    // timing
    // ******************************************************
    localparam int CLK_NS       = 40;
    localparam int UNIT_US      = 8;
    localparam int ERS_LAT_US   = 48;
    localparam int PGM_LAT_US   = 40;
    // longest times round down to whole cycles
    localparam int ERS_LAT_CYC  = (ERS_LAT_US * 1000) / CLK_NS;
    localparam int PGM_LAT_CYC  = (PGM_LAT_US * 1000) / CLK_NS;
    // halting time actually used, well below either bound
    localparam logic [15:0] HALT_CYC = 16'h0010;
    localparam logic [23:0] ERS_WORK = 24'h0008_00;
    localparam logic [23:0] PGM_WORK = 24'h0001_00;
    typedef enum logic [2:0] {
        FSRC_IDLE, FSRC_ERS, FSRC_PGM, FSRC_HALT_E, FSRC_HALT_P,
        FSRC_SUSP_E, FSRC_SUSP_P
    } fsrc_state_e;
endpackage
`default_nettype wire

//--- hw/fsrc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// ******************************************************
// byte stream from the serial front end
// ******************************************************
interface fsrc_link_if;
    logic       cs_active;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic [4:0] byte_index;
    logic       bit_out;
    modport rx (output cs_active, output byte_valid, output byte_data,
                output byte_index, input bit_out);
    modport core (input cs_active, input byte_valid, input byte_data,
                  input byte_index, output bit_out);
endinterface
`default_nettype wire

//--- hw/fsrc_spi_rx.sv
`timescale 1ns/10ps
`default_nettype none
// ******************************************************
// serial shifter: samples sck/cs/si, finds sck edges
// ******************************************************
module fsrc_spi_rx (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // pins
    input  wire logic i_sck,
    input  wire logic i_cs_n,
    input  wire logic i_si,
    output logic      o_so,
    output logic      o_so_oe_n,
    // byte side
    fsrc_link_if.rx   link
);
    typedef struct packed {
        logic [1:0] sck_s, cs_s, si_s;
        logic       sck_d;
        logic [2:0] bitc;
        logic [7:0] sh;
        logic       bv;
        logic [7:0] bd;
        logic [4:0] bidx;
        logic       so;
        logic       oe_n;
    } fsrc_rx_s;
    fsrc_rx_s st, next_st;
    logic rise, fall, act;

    // two flops per pin; only stage [1] is read by logic
    always_comb begin
        next_st = st;
        next_st.sck_s = {st.sck_s[0], i_sck};
        next_st.cs_s  = {st.cs_s[0], i_cs_n};
        next_st.si_s  = {st.si_s[0], i_si};
        next_st.sck_d = st.sck_s[1];
        next_st.bv    = 1'b0;
        if (!act) begin
            next_st.bitc = 3'h0;
            next_st.bidx = 5'h00;
            next_st.oe_n = 1'b1;
        end else begin
            if (rise) begin
                next_st.sh   = {st.sh[6:0], st.si_s[1]};
                next_st.bitc = st.bitc + 3'h1;
                if (st.bitc == 3'h7) begin
                    next_st.bv = 1'b1;
                    next_st.bd = {st.sh[6:0], st.si_s[1]};
                end
            end
            if (st.bv && st.bidx != 5'h1f) begin
                next_st.bidx = st.bidx + 5'h01;
            end
            if (fall) begin // mode 0: drive data on falling edge
                next_st.so   = link.bit_out;
                next_st.oe_n = 1'b0;
            end
        end
    end
    assign act  = ~st.cs_s[1];
    assign rise = st.sck_s[1] & ~st.sck_d;
    assign fall = ~st.sck_s[1] & st.sck_d;

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '{sck_s: 2'h0, cs_s: 2'h3, si_s: 2'h0, sck_d: 1'b0,
                    bitc: 3'h0, sh: 8'h00, bv: 1'b0, bd: 8'h00,
                    bidx: 5'h00, so: 1'b0, oe_n: 1'b1};
        end else begin
            st <= next_st;
        end
    end
    assign link.cs_active  = act;
    assign link.byte_valid = st.bv;
    assign link.byte_data  = st.bd;
    assign link.byte_index = st.bidx;
    assign o_so            = st.so;
    assign o_so_oe_n       = st.oe_n;
endmodule // fsrc_spi_rx
`default_nettype wire

//--- hw/fsrc_suspend_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module fsrc_suspend_ctrl (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // serial pins
    input  wire logic i_sck,
    input  wire logic i_cs_n,
    input  wire logic i_si,
    output logic      o_so,
    output logic      o_so_oe_n,
    // embedded operation starts from the command decoder
    input  wire logic i_start_erase,
    input  wire logic i_start_program,
    // status
    output logic      o_busy,
    output logic      o_erase_suspended,
    output logic      o_program_suspended,
    output logic      o_op_done
);
    fsrc_link_if link ();

    // ******************************************************
    // serial front end
    // ******************************************************
    fsrc_spi_rx u_rx (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_sck     (i_sck),
        .i_cs_n    (i_cs_n),
        .i_si      (i_si),
        .o_so      (o_so),
        .o_so_oe_n (o_so_oe_n),
        .link      (link)
    );

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        fsrc_pkg::fsrc_state_e fsm;
        logic [23:0] ers_left;   // remaining erase work, kept over suspend
        logic [23:0] pgm_left;   // remaining program work
        logic [15:0] halt;
        logic [7:0]  opcode;
        logic [7:0]  paddr;
        logic [2:0]  bitp;
        logic        rd_mode;
        logic        done;
        logic        ers_parked; // erase held under a program
        logic [2:0]  sck_q;      // sck history, [0] is the raw capture
    } fsrc_ctl_s;
    fsrc_ctl_s st, next_st;
    logic [7:0]  cur_byte;
    logic [63:0] tbl;
    logic        cmd_byte;

    // dwords 12 and 13 side by side, low address byte first
    assign tbl = {fsrc_pkg::DW13_VALUE, fsrc_pkg::DW12_VALUE};
    assign cmd_byte = link.byte_valid && link.byte_index == 5'h00;

    // serve table bytes: byte offset (paddr - 2Ch) within the pair
    always_comb begin
        cur_byte = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (st.paddr == fsrc_pkg::DW12_ADDR + 8'(k)) begin
                cur_byte = tbl[k*8 +: 8];
            end
        end
    end
    assign link.bit_out = st.rd_mode ? cur_byte[3'h7 - st.bitp] : 1'b0;

    // main sequencer
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        // two flops before logic; only [1] and [2] are read below
        next_st.sck_q = {st.sck_q[1:0], i_sck};
        if (!link.cs_active) begin
            next_st.rd_mode = 1'b0;
        end
        // parameter read: opcode, one address byte, dummy, then data
        if (link.byte_valid) begin
            if (link.byte_index == 5'h00) begin
                next_st.opcode = link.byte_data;
            end else if (st.opcode == fsrc_pkg::OP_RD_PARAM) begin
                if (link.byte_index == 5'h01) begin
                    next_st.paddr = link.byte_data;
                end else if (link.byte_index == 5'h02) begin
                    next_st.rd_mode = 1'b1;
                    next_st.bitp = 3'h0;
                end else begin
                    next_st.paddr = st.paddr + 8'h01;
                end
            end
        end
        case (st.fsm)
            fsrc_pkg::FSRC_IDLE: begin
                // a second erase is refused while one is parked
                if (i_start_erase && !st.ers_parked) begin
                    next_st.fsm = fsrc_pkg::FSRC_ERS;
                    next_st.ers_left = fsrc_pkg::ERS_WORK;
                end else if (i_start_program) begin
                    next_st.fsm = fsrc_pkg::FSRC_PGM;
                    next_st.pgm_left = fsrc_pkg::PGM_WORK;
                end else if (cmd_byte && st.ers_parked &&
                             link.byte_data == fsrc_pkg::OP_ERS_RESUME) begin
                    next_st.fsm = fsrc_pkg::FSRC_ERS;
                    next_st.ers_parked = 1'b0;
                end
            end
            fsrc_pkg::FSRC_ERS: begin
                if (cmd_byte && link.byte_data == fsrc_pkg::OP_ERS_SUSPEND) begin
                    next_st.fsm = fsrc_pkg::FSRC_HALT_E;
                    next_st.halt = fsrc_pkg::HALT_CYC;
                end else if (st.ers_left == 24'h0) begin
                    next_st.fsm = fsrc_pkg::FSRC_IDLE;
                    next_st.done = 1'b1;
                end else begin
                    next_st.ers_left = st.ers_left - 24'h1;
                end
            end
            fsrc_pkg::FSRC_PGM: begin
                if (cmd_byte && link.byte_data == fsrc_pkg::OP_PGM_SUSPEND) begin
                    next_st.fsm = fsrc_pkg::FSRC_HALT_P;
                    next_st.halt = fsrc_pkg::HALT_CYC;
                end else if (st.pgm_left == 24'h0) begin
                    next_st.fsm = st.ers_parked ? fsrc_pkg::FSRC_SUSP_E
                                                : fsrc_pkg::FSRC_IDLE;
                    next_st.done = 1'b1;
                end else begin
                    next_st.pgm_left = st.pgm_left - 24'h1;
                end
            end
            // halt time fixed far under 48 us
            fsrc_pkg::FSRC_HALT_E: begin
                if (st.halt == 16'h0) begin
                    next_st.fsm = fsrc_pkg::FSRC_SUSP_E;
                    next_st.ers_parked = 1'b1;
                end else begin
                    next_st.halt = st.halt - 16'h1;
                end
            end
            // halt time fixed far under 40 us
            fsrc_pkg::FSRC_HALT_P: begin
                if (st.halt == 16'h0) begin
                    next_st.fsm = fsrc_pkg::FSRC_SUSP_P;
                end else begin
                    next_st.halt = st.halt - 16'h1;
                end
            end
            fsrc_pkg::FSRC_SUSP_E: begin
                // programs may run while erase is parked
                if (i_start_program) begin
                    next_st.fsm = fsrc_pkg::FSRC_PGM;
                    next_st.pgm_left = fsrc_pkg::PGM_WORK;
                end else if (cmd_byte &&
                             link.byte_data == fsrc_pkg::OP_ERS_RESUME) begin
                    next_st.fsm = fsrc_pkg::FSRC_ERS;
                    next_st.ers_parked = 1'b0;
                end
            end
            fsrc_pkg::FSRC_SUSP_P: begin
                if (cmd_byte && link.byte_data == fsrc_pkg::OP_PGM_RESUME) begin
                    next_st.fsm = fsrc_pkg::FSRC_PGM;
                end
            end
            default: next_st.fsm = fsrc_pkg::FSRC_IDLE;
        endcase
        // advance bit pointer on each falling sck of output; restart it at each data byte
        if (st.rd_mode && link.byte_valid && link.byte_index > 5'h02) begin
            next_st.bitp = 3'h0;
        end else if (st.rd_mode && !st.sck_q[1] && st.sck_q[2] &&
                     !link.byte_valid) begin
            // falling sck: the front end loads the pin on this very edge,
            // so the pointer moves just after its bit was taken; both see
            // the edge through the same two-flop delay
            next_st.bitp = st.bitp + 3'h1;
        end
    end

    // state register: one flop bank for the whole struct, sck history
    // included; sck idles low, so clearing it to zero gives no false
    // falling edge after reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '{fsm: fsrc_pkg::FSRC_IDLE, ers_left: 24'h0,
                    pgm_left: 24'h0, halt: 16'h0, opcode: 8'h00,
                    paddr: 8'h00, bitp: 3'h0, rd_mode: 1'b0, done: 1'b0,
                    ers_parked: 1'b0,
                    sck_q: 3'h0};
        end else begin
            st <= next_st;
        end
    end

    // busy while running or halting
    assign o_busy = st.fsm == fsrc_pkg::FSRC_ERS ||
                    st.fsm == fsrc_pkg::FSRC_PGM ||
                    st.fsm == fsrc_pkg::FSRC_HALT_E ||
                    st.fsm == fsrc_pkg::FSRC_HALT_P;
    assign o_erase_suspended   = st.ers_parked;
    assign o_program_suspended = st.fsm == fsrc_pkg::FSRC_SUSP_P;
    assign o_op_done           = st.done;
endmodule // fsrc_suspend_ctrl
`default_nettype wire

//--- verif/fsrc_suspend_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ******************************************************
// port-level checks of the suspend controller
// ******************************************************
module fsrc_suspend_ctrl_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // serial pins
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic o_so,
    input wire logic o_so_oe_n,
    // operation control and status
    input wire logic i_start_erase,
    input wire logic i_start_program,
    input wire logic o_busy,
    input wire logic o_erase_suspended,
    input wire logic o_program_suspended,
    input wire logic o_op_done
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // a halt must leave the array free, and only a running op halts
    a_ers_halt_idle: assert property ($rose(o_erase_suspended) |-> !o_busy)
        else $error("erase suspend left device busy");
    a_pgm_halt_idle: assert property ($rose(o_program_suspended) |-> !o_busy)
        else $error("program suspend left device busy");
    a_ers_halt_cause: assert property ($rose(o_erase_suspended) |-> $past(o_busy, 4))
        else $error("erase suspended without a running op");
    a_pgm_halt_cause: assert property ($rose(o_program_suspended) |-> $past(o_busy, 4))
        else $error("program suspended without a running op");
    // erase resume puts the op back to work within two cycles
    a_ers_resume_busy: assert property ($fell(o_erase_suspended) |-> ##[0:2] o_busy)
        else $error("erase resume did not restart work");
    a_done_from_busy: assert property (o_op_done |-> $past(o_busy))
        else $error("done without preceding busy");
    a_done_one_pulse: assert property (o_op_done |=> !o_op_done)
        else $error("done held longer than one cycle");
    // nothing may drive the data pin between frames
    a_so_quiet_idle: assert property (i_cs_n [*4] |-> o_so_oe_n)
        else $error("data pin driven while deselected");
    c_ers_susp: cover property ($rose(o_erase_suspended));
    c_pgm_susp: cover property ($rose(o_program_suspended));
    c_op_done: cover property (o_op_done);
endmodule // fsrc_suspend_ctrl_monitor
bind fsrc_suspend_ctrl fsrc_suspend_ctrl_monitor u_fsrc_suspend_ctrl_monitor (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sck(i_sck), .i_cs_n(i_cs_n),
    .i_si(i_si), .o_so(o_so), .o_so_oe_n(o_so_oe_n),
    .i_start_erase(i_start_erase), .i_start_program(i_start_program),
    .o_busy(o_busy), .o_erase_suspended(o_erase_suspended),
    .o_program_suspended(o_program_suspended), .o_op_done(o_op_done));
`default_nettype wire

//--- verif/fsrc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ******************************************************
// host spi controller, mode 0, sck 320 ns
// ******************************************************
module fsrc_host_model (
    // clock
    input  wire logic i_clk,
    // serial pins
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_si,
    input  wire logic i_so
);
    // sck stands low between frames
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    task automatic frame_open();
        @(posedge i_clk) o_cs_n <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    // data set while sck low, sampled at end of the high phase
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge i_clk) o_si <= tx[i];
            repeat (3) @(posedge i_clk);
            o_sck <= 1'b1;
            repeat (4) @(posedge i_clk);
            rx[i] = i_so;
            o_sck <= 1'b0;
        end
    endtask
    // released data line toggles so a stale bit is never read
    task automatic frame_close();
        repeat (4) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_si <= ~o_si;
        repeat (8) @(posedge i_clk);
    endtask
endmodule // fsrc_host_model
`default_nettype wire

//--- verif/flash_suspend_resume_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module flash_suspend_resume_control_tb;
    logic clk, rst_n, sck, cs_n, si, so, so_oe_n, st_e, st_p;
    logic busy, esus, psus, done;
    logic so_pin;
    int   n_fail = 0;
    int   cmp_count = 0;
    fsrc_host_model u_fsrc_host_model (.i_clk(clk), .o_sck(sck),
        .o_cs_n(cs_n), .o_si(si), .i_so(so_pin));
    fsrc_suspend_ctrl u_fsrc_suspend_ctrl (.i_clk(clk), .i_rst_n(rst_n),
        .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so(so),
        .o_so_oe_n(so_oe_n), .i_start_erase(st_e), .i_start_program(st_p),
        .o_busy(busy), .o_erase_suspended(esus),
        .o_program_suspended(psus), .o_op_done(done));
    // released pin shows the inverse, so a stale bit cannot pass
    assign so_pin = so_oe_n ? ~so : so;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        logic [7:0] rx;
        u_fsrc_host_model.frame_open();
        u_fsrc_host_model.xfer(op, rx);
        u_fsrc_host_model.frame_close();
    endtask
    task automatic pulse(input logic erase);
        @(posedge clk) begin
            st_e <= erase;
            st_p <= ~erase;
        end
        @(posedge clk) begin
            st_e <= 1'b0;
            st_p <= 1'b0;
        end
    endtask
    // bounded wait, sampled on the falling edge; sel 0 esus 1 psus 2 done
    task automatic wait_for(input int sel, input int lim, output int n);
        n = 0;
        @(negedge clk);
        while (n < lim && !(sel == 0 ? esus : sel == 1 ? psus : done)) begin
            @(negedge clk);
            n++;
        end
    endtask
    // suspend mid-op, refused restart, resume and finish
    task automatic t_susp(input logic erase, input int lat, input int work);
        int n;
        pulse(erase);
        repeat (40) @(posedge clk);
        cmd(erase ? fsrc_pkg::OP_ERS_SUSPEND : fsrc_pkg::OP_PGM_SUSPEND);
        wait_for(erase ? 0 : 1, 2000, n);
        check("halt in time", 32'(n <= lat), 32'h1);
        check("idle after halt", 32'(busy), 32'h0);
        if (erase) begin
            pulse(1'b1);
            repeat (10) @(negedge clk);
            check("nested erase", 32'(busy), 32'h0);
        end
        // no second suspend is issued after this resume
        cmd(erase ? fsrc_pkg::OP_ERS_RESUME
                  : fsrc_pkg::OP_PGM_RESUME);
        @(negedge clk);
        check("flag cleared", 32'(erase ? esus : psus), 32'h0);
        check("busy on resume", 32'(busy), 32'h1);
        wait_for(2, 4000, n);
        check("op completes", 32'(done), 32'h1);
        check("no restart", 32'(n < work - 30), 32'h1);
    endtask
    // parameter dword read-back, lowest address byte first
    task automatic t_param();
        logic [31:0] dw;
        logic [7:0]  rx;
        logic [7:0]  adr [2];
        logic [31:0] exp [2];
        adr = '{8'h2c, 8'h30};
        exp = '{32'h451883ec, 32'h757a858a};
        for (int k = 0; k < 2; k++) begin
            // reads only while nothing is suspended
            u_fsrc_host_model.frame_open();
            u_fsrc_host_model.xfer(fsrc_pkg::OP_RD_PARAM, rx);
            u_fsrc_host_model.xfer(adr[k], rx);
            u_fsrc_host_model.xfer(8'h00, rx);
            for (int b = 0; b < 4; b++) begin
                u_fsrc_host_model.xfer(8'h00, rx);
                dw[8*b +: 8] = rx;
            end
            u_fsrc_host_model.frame_close();
            check("param dword", dw, exp[k]);
            if (k == 0)
                check("support flag", 32'(dw[31]), 32'h0);
        end
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        st_e = 1'b0;
        st_p = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        check("reset status", 32'({busy, esus, psus, so_oe_n}),
              32'h1);
        t_susp(1'b1, fsrc_pkg::ERS_LAT_CYC, int'(fsrc_pkg::ERS_WORK));
        t_susp(1'b0, fsrc_pkg::PGM_LAT_CYC, int'(fsrc_pkg::PGM_WORK));
        t_param();
        final_report();
    end
endmodule // flash_suspend_resume_control_tb
`default_nettype wire
